//--- hdl/ld_cfg_pkg.sv
/*
 Constants and carrier types for the floppy and parallel logical-device
 configuration registers. Assumes a host that selects a logical device
 and an index through the configuration index and data ports.
*/
package ld_cfg_pkg;

    // =========================================================
    // Logical devices and indices
    localparam logic [7:0] LDN_FLOPPY = 8'h00;
    localparam logic [7:0] LDN_PARALLEL = 8'h03;
    localparam logic [7:0] IDX_FLOPPY_MODE = 8'hf0;
    localparam logic [7:0] IDX_FLOPPY_OPTION = 8'hf1;
    localparam logic [7:0] IDX_DRIVE_TYPES = 8'hf2;
    localparam logic [7:0] IDX_RESERVED_ZERO = 8'hf3;
    localparam logic [7:0] IDX_DRIVE0 = 8'hf4;
    localparam logic [7:0] IDX_DRIVE1 = 8'hf5;
    localparam logic [7:0] IDX_PAR_MODE = 8'hf0;
    localparam logic [7:0] IDX_PAR_MODE2 = 8'hf1;
    localparam logic [7:0] IDX_LDN = 8'h07;

    // =========================================================
    // Reset values and writable masks
    localparam logic [7:0] RST_FLOPPY_MODE = 8'h0e;
    localparam logic [7:0] RST_FLOPPY_OPTION = 8'h00;
    localparam logic [7:0] RST_DRIVE_TYPES = 8'hff;
    localparam logic [7:0] RST_DRIVE_CFG = 8'h00;
    localparam logic [7:0] RST_PAR_MODE = 8'h3c;
    localparam logic [7:0] RST_PAR_MODE2 = 8'h00;
    localparam logic [7:0] DRIVE_CFG_WMASK = 8'h5b;
    localparam logic [7:0] RESERVED_ZERO_VAL = 8'h00;
    localparam logic [4:0] SYNC_RST = 5'h07;

    // =========================================================
    // Field positions
    localparam int FM_ENHANCED = 0;
    localparam int FM_NONBURST = 1;
    localparam int FM_IFACE_LO = 2;
    localparam int FM_PUSH_PULL = 6;
    localparam int FO_FORCE_WP = 0;
    localparam int FO_DENS_LO = 2;
    localparam int DC_RATE_LO = 3;
    localparam int DC_PRECOMP_OFF = 6;
    localparam int PM_THR_LO = 3;
    localparam int PM_IRQ_PULSE = 7;
    localparam int PM2_TMO_SEL = 4;

    // =========================================================
    // Enumerations
    typedef enum logic [1:0] {
        IF_COMPACT = 2'b00,
        IF_ALT = 2'b01,
        IF_RESERVED = 2'b10,
        IF_AT = 2'b11
    } iface_mode_t;

    typedef enum logic [2:0] {
        PM_SPP = 3'b000,
        PM_EPP19 = 3'b001,
        PM_ECP = 3'b010,
        PM_ECP_EPP19 = 3'b011,
        PM_PRINTER = 3'b100,
        PM_EPP17 = 3'b101,
        PM_RSVD6 = 3'b110,
        PM_ECP_EPP17 = 3'b111
    } par_mode_t;

    typedef enum logic [1:0] {
        DENS_NORMAL = 2'b00,
        DENS_NORMAL_USER = 2'b01,
        DENS_ONE = 2'b10,
        DENS_ZERO = 2'b11
    } dens_sel_t;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic enhanced_mode;
        logic nonburst_dma;
        iface_mode_t iface_mode;
        logic open_drain_drive;
        logic [1:0] drive0_type;
        logic [1:0] drive1_type;
        logic [1:0] rate_table0;
        logic [1:0] rate_table1;
        logic precomp_disable0;
        logic precomp_disable1;
        logic [1:0] drive_a_type;
        logic [1:0] drive_b_type;
    } floppy_ctl_t;

    typedef struct packed {
        par_mode_t port_mode;
        logic [3:0] fifo_threshold;
        logic irq_pulsed;
        logic irq_type_valid;
        logic timeout_clear_on_read;
    } parallel_ctl_t;

    typedef struct packed {
        logic [7:0] ldn;
        logic [7:0] floppy_mode;
        logic [7:0] floppy_option;
        logic [7:0] drive_types;
        logic [7:0] drive0;
        logic [7:0] drive1;
        logic [7:0] par_mode;
        logic [7:0] par_mode2;
        logic [7:0] rdata;
        logic wp_out;
        logic density_out;
        logic density_forced;
        floppy_ctl_t fctl;
        parallel_ctl_t pctl;
    } cfg_state_t;

endpackage

//--- hdl/ld_cfg_regs.sv
/*
 Floppy and parallel logical-device configuration register set.
 Assumes the configuration port decoder supplies the current index with
 one-cycle read and write strobes on this clock; pins arrive asynchronous.
*/
`timescale 1ns/100ps
module ld_cfg_regs
    import ld_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Configuration data port, index already latched by the port decoder
    input wire logic [7:0] cfg_index,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_write,
    input wire logic cfg_read,
    output logic [7:0] cfg_rdata,
    // Floppy pins and core inputs
    input wire logic drive_select_zero_n,
    input wire logic drive_select_one_n,
    input wire logic write_protect_input_n,
    input wire logic floppy_disable_protect,
    input wire logic density_core,
    // Floppy outputs
    output logic floppy_status_a_wp,
    output logic density_out,
    output floppy_ctl_t floppy_ctl,
    // Parallel port controls
    output parallel_ctl_t parallel_ctl
);
    import ld_cfg_pkg::*;

    // =========================================================
    // Pin synchronisers, two flops per input before any logic
    logic [4:0] pin_raw;
    logic [4:0] sync_meta;
    logic [4:0] sync_out;
    logic [2:0] pin_sync;
    logic [1:0] dens_sync;

    assign pin_raw = {floppy_disable_protect, density_core, write_protect_input_n,
        drive_select_one_n, drive_select_zero_n};

    generate
        for (genvar g = 0; g < 5; g++) begin : g_sync
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    sync_meta[g] <= SYNC_RST[g];
                    sync_out[g] <= SYNC_RST[g];
                end else begin
                    sync_meta[g] <= pin_raw[g];
                    sync_out[g] <= sync_meta[g];
                end
            end
        end
    endgenerate

    // Active-low pins idle high in reset, so no false select follows it
    assign pin_sync = sync_out[2:0];
    assign dens_sync = sync_out[4:3];

    // =========================================================
    // Index decode
    function automatic logic hit(input logic [7:0] ldn, input logic [7:0] dev,
                                 input logic [7:0] idx, input logic [7:0] want);
        hit = (ldn == dev) && (idx == want);
    endfunction

    // =========================================================
    // Write decode; the select byte sits outside both devices
    function automatic cfg_state_t apply_write(
        input cfg_state_t s,
        input logic [7:0] idx,
        input logic [7:0] wdata
    );
        cfg_state_t n;
        n = s;
        if (idx == IDX_LDN) begin
            n.ldn = wdata;
        end

        // Floppy device bytes
        if (hit(s.ldn, LDN_FLOPPY, idx, IDX_FLOPPY_MODE)) begin
            n.floppy_mode = wdata;
        end
        if (hit(s.ldn, LDN_FLOPPY, idx, IDX_FLOPPY_OPTION)) begin
            n.floppy_option = wdata;
        end
        if (hit(s.ldn, LDN_FLOPPY, idx, IDX_DRIVE_TYPES)) begin
            n.drive_types = wdata;
        end
        // Read-only bits never take a write
        if (hit(s.ldn, LDN_FLOPPY, idx, IDX_DRIVE0)) begin
            n.drive0 = wdata & DRIVE_CFG_WMASK;
        end
        if (hit(s.ldn, LDN_FLOPPY, idx, IDX_DRIVE1)) begin
            n.drive1 = wdata & DRIVE_CFG_WMASK;
        end

        // Parallel device bytes
        if (hit(s.ldn, LDN_PARALLEL, idx, IDX_PAR_MODE)) begin
            n.par_mode = wdata;
        end
        // Reserved bits stored as written; software keeps them zero
        if (hit(s.ldn, LDN_PARALLEL, idx, IDX_PAR_MODE2)) begin
            n.par_mode2 = wdata;
        end
        return n;
    endfunction

    // =========================================================
    // Control decode, shared by the live path and the reset values
    function automatic floppy_ctl_t floppy_decode(
        input logic [7:0] mode,
        input logic [7:0] types,
        input logic [7:0] drv0,
        input logic [7:0] drv1
    );
        floppy_ctl_t f;
        f = '0;

        // Mode byte
        f.enhanced_mode = mode[FM_ENHANCED];
        f.nonburst_dma = mode[FM_NONBURST];
        f.iface_mode = iface_mode_t'(mode[FM_IFACE_LO +: 2]);
        f.open_drain_drive = !mode[FM_PUSH_PULL];

        // Per-drive configuration
        f.drive0_type = drv0[1:0];
        f.drive1_type = drv1[1:0];
        f.rate_table0 = drv0[DC_RATE_LO +: 2];
        f.rate_table1 = drv1[DC_RATE_LO +: 2];
        f.precomp_disable0 = drv0[DC_PRECOMP_OFF];
        f.precomp_disable1 = drv1[DC_PRECOMP_OFF];

        // Drive types; the upper pairs are storage only
        f.drive_a_type = types[1:0];
        f.drive_b_type = types[3:2];
        return f;
    endfunction

    function automatic parallel_ctl_t parallel_decode(
        input logic [7:0] pmode,
        input logic [7:0] pmode2
    );
        parallel_ctl_t p;
        logic [2:0] sel;
        sel = pmode[2:0];
        p = '0;

        p.port_mode = par_mode_t'(sel);
        p.fifo_threshold = pmode[PM_THR_LO +: 4];

        // Type bit means nothing in printer or standard modes
        p.irq_type_valid = (sel != PM_PRINTER) && (sel != PM_SPP);
        p.irq_pulsed = p.irq_type_valid && pmode[PM_IRQ_PULSE];

        // Timeout flag clear style for the port core
        p.timeout_clear_on_read = pmode2[PM2_TMO_SEL];
        return p;
    endfunction

    // =========================================================
    // Pin-derived levels
    // Forced protect only bites on a selected drive
    function automatic logic protect_level(
        input logic [2:0] pins_n,
        input logic disable_protect,
        input logic force_protect
    );
        logic sel0;
        logic sel1;
        logic term0;
        logic term1;
        logic pin_term;
        sel0 = !pins_n[0];
        sel1 = !pins_n[1];
        term0 = sel0 && force_protect;
        term1 = sel1 && force_protect;
        pin_term = !pins_n[2];
        return term0 || term1 || pin_term || disable_protect;
    endfunction

    function automatic logic density_level(
        input logic [7:0] option,
        input logic core_level
    );
        logic level;
        level = core_level;
        case (dens_sel_t'(option[FO_DENS_LO +: 2]))
            DENS_ONE: begin
                level = 1'b1;
            end
            DENS_ZERO: begin
                level = 1'b0;
            end
            default: begin
                level = core_level;
            end
        endcase
        return level;
    endfunction

    // =========================================================
    // Read multiplexers, one per logical device
    function automatic logic [7:0] floppy_read(
        input logic [7:0] idx,
        input cfg_state_t s
    );
        logic [7:0] value;
        value = 8'h00;
        case (idx)
            IDX_FLOPPY_MODE: begin
                value = s.floppy_mode;
            end
            IDX_FLOPPY_OPTION: begin
                value = s.floppy_option;
            end
            IDX_DRIVE_TYPES: begin
                value = s.drive_types;
            end
            IDX_RESERVED_ZERO: begin
                value = RESERVED_ZERO_VAL;
            end
            // Fixed bits masked on read as well as on write
            IDX_DRIVE0: begin
                value = s.drive0 & DRIVE_CFG_WMASK;
            end
            IDX_DRIVE1: begin
                value = s.drive1 & DRIVE_CFG_WMASK;
            end
            default: begin
                value = 8'h00;
            end
        endcase
        return value;
    endfunction

    function automatic logic [7:0] parallel_read(
        input logic [7:0] idx,
        input cfg_state_t s
    );
        logic [7:0] value;
        value = 8'h00;
        case (idx)
            IDX_PAR_MODE: begin
                value = s.par_mode;
            end
            IDX_PAR_MODE2: begin
                value = s.par_mode2;
            end
            default: begin
                value = 8'h00;
            end
        endcase
        return value;
    endfunction

    // Unmapped devices read zero rather than a stale byte
    function automatic logic [7:0] read_value(
        input logic [7:0] idx,
        input cfg_state_t s
    );
        logic [7:0] value;
        value = 8'h00;
        if (idx == IDX_LDN) begin
            value = s.ldn;
        end else if (s.ldn == LDN_FLOPPY) begin
            value = floppy_read(idx, s);
        end else if (s.ldn == LDN_PARALLEL) begin
            value = parallel_read(idx, s);
        end
        return value;
    endfunction

    // =========================================================
    // State
    cfg_state_t st_reg;
    cfg_state_t st_next;

    always_comb begin
        logic fwp;
        st_next = st_reg;
        fwp = st_reg.floppy_option[FO_FORCE_WP];

        // Host writes through the data port at the selected index
        if (cfg_write) begin
            st_next = apply_write(st_reg, cfg_index, cfg_wdata);
        end

        // Read data, registered so the port sees it a cycle later
        st_next.rdata = 8'h00;
        if (cfg_read) begin
            st_next.rdata = read_value(cfg_index, st_reg);
        end

        // Write protect to the core; pins are active low
        st_next.wp_out = protect_level(pin_sync, dens_sync[1], fwp);

        // Density override
        st_next.density_out = density_level(st_reg.floppy_option, dens_sync[0]);
        st_next.density_forced = st_reg.floppy_option[FO_DENS_LO + 1];

        // Controls follow the stored bytes one cycle behind
        st_next.fctl = floppy_decode(st_reg.floppy_mode, st_reg.drive_types,
            st_reg.drive0, st_reg.drive1);
        st_next.pctl = parallel_decode(st_reg.par_mode, st_reg.par_mode2);
    end

    // Only power-on or bus reset reaches nrst; soft reset is not wired here
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_reg.ldn <= '0;
            st_reg.floppy_mode <= RST_FLOPPY_MODE;
            st_reg.floppy_option <= RST_FLOPPY_OPTION;
            st_reg.drive_types <= RST_DRIVE_TYPES;
            st_reg.drive0 <= RST_DRIVE_CFG;
            st_reg.drive1 <= RST_DRIVE_CFG;
            st_reg.par_mode <= RST_PAR_MODE;
            st_reg.par_mode2 <= RST_PAR_MODE2;
            st_reg.rdata <= '0;
            st_reg.wp_out <= 1'b0;
            st_reg.density_out <= 1'b0;
            st_reg.density_forced <= 1'b0;

            // Controls start as the decode of the default bytes
            st_reg.fctl <= floppy_decode(RST_FLOPPY_MODE, RST_DRIVE_TYPES,
                RST_DRIVE_CFG, RST_DRIVE_CFG);
            st_reg.pctl <= parallel_decode(RST_PAR_MODE, RST_PAR_MODE2);
        end else begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // Outputs
    assign cfg_rdata = st_reg.rdata;
    assign floppy_status_a_wp = st_reg.wp_out;
    assign density_out = st_reg.density_out;
    assign floppy_ctl = st_reg.fctl;
    assign parallel_ctl = st_reg.pctl;

endmodule

//--- tb/ld_cfg_regs_assertions.sv
/* Checker for the logical-device configuration register set.
   Assumes it is bound to ld_cfg_regs and sees its ports only. */
`timescale 1ns/100ps
module ld_cfg_checks
    import ld_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Config data port
    input wire logic [7:0] cfg_index,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_write,
    input wire logic cfg_read,
    input wire logic [7:0] cfg_rdata,
    // Pins
    input wire logic drive_select_zero_n,
    input wire logic drive_select_one_n,
    input wire logic write_protect_input_n,
    input wire logic floppy_disable_protect,
    input wire logic density_core,
    // Outputs
    input wire logic floppy_status_a_wp,
    input wire logic density_out,
    input wire floppy_ctl_t floppy_ctl,
    input wire parallel_ctl_t parallel_ctl
);
    // ==========
    // Properties
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    a_rdata_idle: assert property (
        !$past(cfg_read) |-> cfg_rdata == 8'h00) else $error("read data not idle");
    a_zero_index: assert property (
        cfg_read && cfg_index == IDX_RESERVED_ZERO |=> cfg_rdata == 8'h00)
        else $error("fixed index not zero");
    a_drive_fixed: assert property (
        cfg_read && cfg_index[7:1] == 7'h7a |=> (cfg_rdata & 8'ha4) == 8'h00)
        else $error("drive fixed bits set");
    // Four samples cover the pin synchroniser depth
    a_wp_set: assert property (
        (!write_protect_input_n || floppy_disable_protect) [*4] |-> floppy_status_a_wp)
        else $error("protect not asserted");
    a_wp_clear: assert property (
        (write_protect_input_n && !floppy_disable_protect && drive_select_zero_n
        && drive_select_one_n) [*4] |-> !floppy_status_a_wp) else $error("protect stuck");
    a_ctl_hold: assert property (
        !cfg_write [*4] |-> $stable(floppy_ctl) && $stable(parallel_ctl))
        else $error("controls moved without write");
    a_irq_gated: assert property (
        parallel_ctl.port_mode inside {PM_PRINTER, PM_SPP} |-> !parallel_ctl.irq_pulsed)
        else $error("interrupt type not ignored");
    a_reset_dflt: assert property (
        !$past(nrst) |-> floppy_ctl.iface_mode == IF_AT && floppy_ctl.nonburst_dma
        && parallel_ctl.port_mode == PM_PRINTER && parallel_ctl.fifo_threshold == 4'h7)
        else $error("control defaults wrong");
endmodule
bind ld_cfg_regs ld_cfg_checks i_ld_cfg_checks (.clock, .nrst, .cfg_index, .cfg_wdata,
    .cfg_write, .cfg_read, .cfg_rdata, .drive_select_zero_n, .drive_select_one_n,
    .write_protect_input_n, .floppy_disable_protect, .density_core, .floppy_status_a_wp,
    .density_out, .floppy_ctl, .parallel_ctl);

//--- tb/cfg_host.sv
/* Host model driving the configuration data port.
   Assumes the index port decoding happens upstream of the block. */
`timescale 1ns/100ps
module cfg_host (
    // Config data port
    input wire logic clock,
    output logic [7:0] cfg_index,
    output logic [7:0] cfg_wdata,
    output logic cfg_write,
    output logic cfg_read,
    input wire logic [7:0] cfg_rdata
);
    initial begin
        cfg_index = 8'h00;
        cfg_wdata = 8'h00;
        cfg_write = 1'b0;
        cfg_read = 1'b0;
    end
    // ==========
    // Accesses, one strobe cycle each
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        @(negedge clock);
        cfg_index = idx;
        cfg_wdata = val;
        cfg_write = 1'b1;
        @(negedge clock);
        cfg_write = 1'b0;
        cfg_wdata = ~val; // Stale data never looks valid
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] val);
        @(negedge clock);
        cfg_index = idx;
        cfg_read = 1'b1;
        @(negedge clock);
        cfg_read = 1'b0;
        val = cfg_rdata;
    endtask
endmodule

//--- tb/testbench.sv
/* Self-checking bench for the configuration register set.
   Assumes the host model and the bound checker. */
`timescale 1ns/100ps
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: %s", $time, m); end end
module testbench;
    import ld_cfg_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] cfg_index, cfg_wdata, cfg_rdata;
    logic cfg_write, cfg_read, wp, dens;
    logic ds0_n = 1'b1, ds1_n = 1'b1, wpin_n = 1'b1, dis = 1'b0, core = 1'b0;
    floppy_ctl_t fc;
    parallel_ctl_t pc;
    int errors = 0;
    int tests_run = 0;
    always #50 clock = ~clock;
    cfg_host i_cfg_host (.clock(clock), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
        .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_rdata(cfg_rdata));
    ld_cfg_regs i_ld_cfg_regs (.clock(clock), .nrst(nrst), .cfg_index(cfg_index),
        .cfg_wdata(cfg_wdata), .cfg_write(cfg_write), .cfg_read(cfg_read),
        .cfg_rdata(cfg_rdata), .drive_select_zero_n(ds0_n), .drive_select_one_n(ds1_n),
        .write_protect_input_n(wpin_n), .floppy_disable_protect(dis),
        .density_core(core), .floppy_status_a_wp(wp), .density_out(dens),
        .floppy_ctl(fc), .parallel_ctl(pc));
    // ==========
    // Tasks
    task automatic close_out;
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        i_cfg_host.rd(idx, r);
        `CHK(r, exp, "readback")
    endtask
    task automatic wr_rd(input logic [7:0] idx, input logic [7:0] val, input logic [7:0] exp);
        i_cfg_host.wr(idx, val);
        rd_chk(idx, exp);
    endtask
    // Pins pass a two-flop synchroniser, so allow a margin
    task automatic settle;
        repeat (4) @(negedge clock);
    endtask
    // ==========
    // Sequence
    initial begin
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        i_cfg_host.wr(IDX_LDN, LDN_FLOPPY);
        rd_chk(IDX_FLOPPY_MODE, 8'h0e);
        rd_chk(IDX_FLOPPY_OPTION, 8'h00);
        rd_chk(IDX_DRIVE_TYPES, 8'hff);
        wr_rd(IDX_RESERVED_ZERO, 8'hff, 8'h00);
        rd_chk(IDX_DRIVE0, 8'h00);
        rd_chk(IDX_DRIVE1, 8'h00);
        wr_rd(IDX_DRIVE0, 8'hff, 8'h5b);
        `CHK({fc.drive0_type, fc.rate_table0, fc.precomp_disable0}, 5'h1f, "drv0")
        wr_rd(IDX_DRIVE1, 8'ha4, 8'h00);
        wr_rd(IDX_DRIVE1, 8'h4a, 8'h4a);
        `CHK({fc.drive1_type, fc.rate_table1, fc.precomp_disable1}, 5'h13, "drv1")
        wr_rd(IDX_DRIVE_TYPES, 8'h1b, 8'h1b);
        `CHK({fc.drive_a_type, fc.drive_b_type}, 4'he, "types")
        for (int i = 0; i < 4; i++) begin
            wr_rd(IDX_FLOPPY_MODE, {1'b0, i[0], 1'b0, ~i[0], i[1:0], ~i[0], i[0]},
                {1'b0, i[0], 1'b0, ~i[0], i[1:0], ~i[0], i[0]});
            `CHK(fc.iface_mode, iface_mode_t'(i[1:0]), "iface")
            `CHK({fc.enhanced_mode, fc.nonburst_dma, fc.open_drain_drive},
                {i[0], ~i[0], ~i[0]}, "fmode")
        end
        for (int i = 0; i < 4; i++) begin
            core = i[0];
            wr_rd(IDX_FLOPPY_OPTION, {4'h5, i[1:0], 2'b00}, {4'h5, i[1:0], 2'b00});
            settle;
            `CHK(dens, (i < 2) ? i[0] : ~i[0], "density")
        end
        for (int i = 0; i < 32; i++) begin
            {ds0_n, ds1_n, wpin_n, dis} = i[3:0];
            i_cfg_host.wr(IDX_FLOPPY_OPTION, {7'h00, i[4]});
            settle;
            `CHK(wp, (i[4] & ~(i[3] & i[2])) | ~i[1] | i[0], "protect")
        end
        @(negedge clock);
        nrst = 1'b0;
        @(negedge clock);
        nrst = 1'b1;
        rd_chk(IDX_FLOPPY_MODE, 8'h0e);
        rd_chk(IDX_DRIVE1, 8'h00);
        rd_chk(8'h20, 8'h00);
        i_cfg_host.wr(IDX_LDN, LDN_PARALLEL);
        rd_chk(IDX_PAR_MODE, 8'h3c);
        rd_chk(IDX_PAR_MODE2, 8'h00);
        rd_chk(IDX_DRIVE0, 8'h00);
        for (int i = 0; i < 8; i++) begin
            if (i != 6) begin
                wr_rd(IDX_PAR_MODE, {5'h19, i[2:0]}, {5'h19, i[2:0]});
                `CHK({pc.port_mode, pc.fifo_threshold}, {i[2:0], 4'h9}, "pmode")
                `CHK(pc.irq_pulsed, (i != 0 && i != 4), "irq")
            end
        end
        wr_rd(IDX_PAR_MODE, 8'h3d, 8'h3d);
        `CHK(pc.irq_pulsed, 1'b0, "irq level")
        for (int i = 1; i >= 0; i--) begin
            wr_rd(IDX_PAR_MODE2, {3'b000, i[0], 4'h0}, {3'b000, i[0], 4'h0});
            `CHK(pc.timeout_clear_on_read, i[0], "timeout sel")
        end
        close_out;
    end
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        close_out;
    end
endmodule
